// >>> src/mdcs_regs.svh
// Word offsets, field positions and limits of the channel status bank.
// Assumes word addressing: one 16-bit database word per address.
`ifndef MDCS_REGS_SVH
`define MDCS_REGS_SVH
`define MDCS_OFF_MAIN 7'h30
`define MDCS_OFF_LINK 7'h31
`define MDCS_OFF_ERRMAP 7'h32
`define MDCS_OFF_POLLMAP 7'h33
`define MDCS_OFF_LONGMAP 7'h34
`define MDCS_OFF_CMDIDX 7'h35
`define MDCS_OFF_REQCNT 7'h36
`define MDCS_OFF_RSPCNT 7'h37
`define MDCS_OFF_CFGERR 7'h38
`define MDCS_OFF_CURCODE 7'h39
`define MDCS_OFF_LASTCODE 7'h3a
`define MDCS_NCMD 100
`define MDCS_CE_EN 0
`define MDCS_CE_HH 1
`define MDCS_CE_PM 2
`define MDCS_CE_PRE 3
`define MDCS_CE_SRTY 4
`define MDCS_CE_LRTY 5
`define MDCS_CE_ERTY 6
`define MDCS_CE_POLL 7
`define MDCS_CE_DB 8
`define MDCS_CE_CNT 9
`define MDCS_CE_MCMD 10
`define MDCS_CE_MFIX 11
`define MDCS_CE_MBUF 12
`define MDCS_CE_BOARD 13
`define MDCS_CE_INIT 14
`define MDCS_YES 8'h59
`define MDCS_NO 8'h4e
`define MDCS_PRE_MIN 8'h01
`define MDCS_CNT_MAX 8'h32
`define MDCS_POLL_MAX 16'h2710
`define MDCS_TIMEOUT_WORD 16'hffff
`endif

// >>> src/mdcs_pkg.sv
// Types shared by the channel status bank and its neighbours.
// Assumes mdcs_regs.svh supplies the command list depth.
`include "mdcs_regs.svh"
package mdcs_pkg;
  // Main channel sequencer value
  typedef enum logic [2:0] {
    MDCS_M_POLL = 3'h0, MDCS_M_CFG = 3'h1, MDCS_M_DATA = 3'h2,
    MDCS_M_USER = 3'h3, MDCS_M_WAITID = 3'h4
  } mdcs_main_t;
  // Communication sequencer value
  typedef enum logic [2:0] {
    MDCS_L_START = 3'h0, MDCS_L_IDLE = 3'h1, MDCS_L_TXPEND = 3'h2,
    MDCS_L_TX = 3'h3, MDCS_L_RX = 3'h4, MDCS_L_POSTTX = 3'h5,
    MDCS_L_IDLEWAIT = 3'h6
  } mdcs_link_t;
  // How a command ended
  typedef enum logic [1:0] {
    MDCS_K_REPLY = 2'h0, MDCS_K_COMM = 2'h1, MDCS_K_TIMEOUT = 2'h2
  } mdcs_kind_t;
  // Channel settings checked at configuration
  typedef struct packed {
    logic [7:0] en_yn;
    logic [7:0] hh_yn;
    logic [7:0] pm_yn;
    logic [7:0] preambles;
    logic [7:0] short_rty;
    logic [7:0] long_rty;
    logic [7:0] err_rty;
    logic [15:0] poll_ms;
    logic db_bad;
    logic cnt_bad;
    logic mem_cmd_fail;
    logic mem_fix_fail;
    logic mem_buf_fail;
    logic board_absent;
    logic init_fail;
  } mdcs_cfg_t;
  // Outcome of one executed command
  typedef struct packed {
    logic [6:0] idx;
    mdcs_kind_t kind;
    logic [6:0] code;
    logic [7:0] malf;
  } mdcs_done_t;
  // Whole state of the bank
  typedef struct packed {
    mdcs_main_t main_st;
    mdcs_link_t link_st;
    logic [15:0] err_map;
    logic [15:0] poll_map;
    logic [15:0] long_map;
    logic [6:0] cmd_idx;
    logic [15:0] req_cnt;
    logic [15:0] rsp_cnt;
    logic [15:0] cfg_err;
    logic [15:0] cur_code;
    logic [15:0] last_code;
    logic [`MDCS_NCMD-1:0][15:0] list;
    logic [15:0] rd_data;
    logic rd_valid;
    logic [15:0] ret_word;
    logic ret_valid;
    logic db_wr;
    logic [15:0] db_addr;
    logic [15:0] db_data;
  } mdcs_state_t;
endpackage : mdcs_pkg

// >>> src/mdcs_status.sv
// Status word bank of one multi-drop field-bus master channel.
// Assumes the channel engine drives its state, maps and event pulses
// synchronously to mclk_i, and the host reads through the word port.
// Operation
// - Word 48 shows main sequencer value
// - Word 49 shows communication sequencer value
// - Error bitmap, bit n is slave n
// - Poll bitmap, bit n is slave n
// - Long address bitmap, bit n is slave n
// - Word 53 holds executing command index
// - Word 54 counts requests sent
// - Word 55 counts responses received
// - Words 56-58: config, current, last error
// - Bits 0-2 flag non yes/no settings
// - Bits 3-5 flag preamble, retry counts
// - Bits 6-7 flag error retries, poll time
// - Bits 8-9 flag database address, count
// - Bits 10-12 flag allocation failures
// - Bits 13-14 flag missing board, init
// - One config word per channel, published
// - Command status word returned first
// - List word k is command k
// - Comm failure: top bit, code, zero low
// - Command error: code high, malfunction low
// - Timeout writes all ones
// - List copied at configured database offset
`timescale 1ns/1ps
`include "mdcs_regs.svh"
module mdcs_status (
  input wire logic mclk_i, // 100 MHz clock
  input wire logic rst_b_i, // Async reset, low
  input wire mdcs_pkg::mdcs_main_t main_st_i, // Main sequencer
  input wire mdcs_pkg::mdcs_link_t link_st_i, // Comm sequencer
  input wire logic [15:0] err_map_i, // Slaves in error
  input wire logic [15:0] poll_map_i, // Slaves polled
  input wire logic [15:0] long_map_i, // Slaves on long addr
  input wire logic [6:0] cmd_idx_i, // Executing entry
  input wire logic req_sent_i, // Request sent pulse
  input wire logic rsp_rcvd_i, // Response seen pulse
  input wire logic cfg_load_i, // Check settings pulse
  input wire mdcs_pkg::mdcs_cfg_t cfg_i, // Channel settings
  input wire logic err_rpt_i, // Error report pulse
  input wire logic [15:0] err_code_i, // Reported code
  input wire logic done_i, // Command ended pulse
  input wire mdcs_pkg::mdcs_done_t done_info_i, // Outcome
  input wire logic [15:0] err_off_i, // List database base
  input wire logic rd_en_i, // Read request
  input wire logic rd_list_i, // 1: list, 0: status
  input wire logic [6:0] rd_addr_i, // Word address
  output logic [15:0] rd_data_o, // Read word
  output logic rd_valid_o, // Read word valid
  output logic [15:0] ret_word_o, // First returned word
  output logic ret_valid_o, // Returned word pulse
  output logic db_wr_o, // Database write pulse
  output logic [15:0] db_addr_o, // Database address
  output logic [15:0] db_data_o // Database data
);
  import mdcs_pkg::*;

  logic [1:0] rst_sync_q; // Reset release pipeline
  logic rst_n; // Synchronised reset
  mdcs_state_t s_q; // Registered state
  mdcs_state_t s_d; // Next state

  // Yes or no setting is legal
  function automatic logic yn_ok(input logic [7:0] c);
    yn_ok = (c == `MDCS_YES) || (c == `MDCS_NO);
  endfunction : yn_ok

  // Builds the configuration error word from settings
  function automatic logic [15:0] cfg_word(input mdcs_cfg_t c);
    logic [15:0] w;
    w = 16'h0000;
    w[`MDCS_CE_EN] = !yn_ok(c.en_yn);
    w[`MDCS_CE_HH] = !yn_ok(c.hh_yn);
    w[`MDCS_CE_PM] = !yn_ok(c.pm_yn);
    w[`MDCS_CE_PRE] = (c.preambles < `MDCS_PRE_MIN) ||
      (c.preambles > `MDCS_CNT_MAX);
    w[`MDCS_CE_SRTY] = c.short_rty > `MDCS_CNT_MAX;
    w[`MDCS_CE_LRTY] = c.long_rty > `MDCS_CNT_MAX;
    w[`MDCS_CE_ERTY] = c.err_rty > `MDCS_CNT_MAX;
    w[`MDCS_CE_POLL] = c.poll_ms > `MDCS_POLL_MAX;
    w[`MDCS_CE_DB] = c.db_bad;
    w[`MDCS_CE_CNT] = c.cnt_bad;
    w[`MDCS_CE_MCMD] = c.mem_cmd_fail;
    w[`MDCS_CE_MFIX] = c.mem_fix_fail;
    w[`MDCS_CE_MBUF] = c.mem_buf_fail;
    w[`MDCS_CE_BOARD] = c.board_absent;
    w[`MDCS_CE_INIT] = c.init_fail;
    cfg_word = w;
  endfunction : cfg_word

  // Encodes a command outcome into its status word
  function automatic logic [15:0] enc(input mdcs_done_t d);
    case (d.kind)
      MDCS_K_COMM: enc = {1'b1, d.code, 8'h00};
      MDCS_K_TIMEOUT: enc = `MDCS_TIMEOUT_WORD;
      MDCS_K_REPLY: enc = {1'b0, d.code, d.malf};
      default: enc = `MDCS_TIMEOUT_WORD;
    endcase
  endfunction : enc

  // Releases reset through two flops
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Next-state logic for the whole bank
  always_comb begin
    s_d = s_q;
    s_d.rd_valid = 1'b0;
    s_d.ret_valid = 1'b0;
    s_d.db_wr = 1'b0;
    // Sequencer values and current entry follow the engine
    s_d.main_st = main_st_i;
    s_d.link_st = link_st_i;
    s_d.cmd_idx = cmd_idx_i;
    // Bit 0 has no slave and always reads clear
    s_d.err_map = {err_map_i[15:1], 1'b0};
    s_d.poll_map = {poll_map_i[15:1], 1'b0};
    s_d.long_map = {long_map_i[15:1], 1'b0};
    // Counters roll over rather than stick at the top
    if (req_sent_i) begin
      s_d.req_cnt = s_q.req_cnt + 16'h0001;
    end
    if (rsp_rcvd_i) begin
      s_d.rsp_cnt = s_q.rsp_cnt + 16'h0001;
    end
    // Settings are judged once per load
    if (cfg_load_i) begin
      s_d.cfg_err = cfg_word(cfg_i);
    end
    // New code becomes current, old current becomes last
    if (err_rpt_i) begin
      s_d.cur_code = err_code_i;
      s_d.last_code = s_q.cur_code;
    end
    // Entries beyond the list are dropped
    if (done_i && (done_info_i.idx < 7'(`MDCS_NCMD))) begin
      s_d.list[done_info_i.idx] = enc(done_info_i);
      s_d.ret_word = enc(done_info_i);
      s_d.ret_valid = 1'b1;
      s_d.db_wr = 1'b1;
      s_d.db_addr = err_off_i + {9'h000, done_info_i.idx};
      s_d.db_data = enc(done_info_i);
    end
    // Word read port, answer one cycle later
    if (rd_en_i) begin
      s_d.rd_valid = 1'b1;
      s_d.rd_data = 16'h0000;
      if (rd_list_i) begin
        if (rd_addr_i < 7'(`MDCS_NCMD)) begin
          s_d.rd_data = s_q.list[rd_addr_i];
        end
      end else begin
        case (rd_addr_i)
          `MDCS_OFF_MAIN: s_d.rd_data = {13'h0000, s_q.main_st};
          `MDCS_OFF_LINK: s_d.rd_data = {13'h0000, s_q.link_st};
          `MDCS_OFF_ERRMAP: s_d.rd_data = s_q.err_map;
          `MDCS_OFF_POLLMAP: s_d.rd_data = s_q.poll_map;
          `MDCS_OFF_LONGMAP: s_d.rd_data = s_q.long_map;
          `MDCS_OFF_CMDIDX: s_d.rd_data = {9'h000, s_q.cmd_idx};
          `MDCS_OFF_REQCNT: s_d.rd_data = s_q.req_cnt;
          `MDCS_OFF_RSPCNT: s_d.rd_data = s_q.rsp_cnt;
          `MDCS_OFF_CFGERR: s_d.rd_data = s_q.cfg_err;
          `MDCS_OFF_CURCODE: s_d.rd_data = s_q.cur_code;
          `MDCS_OFF_LASTCODE: s_d.rd_data = s_q.last_code;
          // Spare and unmapped words read zero
          default: s_d.rd_data = 16'h0000;
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign rd_data_o = s_q.rd_data;
  assign rd_valid_o = s_q.rd_valid;
  assign ret_word_o = s_q.ret_word;
  assign ret_valid_o = s_q.ret_valid;
  assign db_wr_o = s_q.db_wr;
  assign db_addr_o = s_q.db_addr;
  assign db_data_o = s_q.db_data;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  // Main state readback
  main_read_a: assert property (
    rd_en_i && !rd_list_i && rd_addr_i == `MDCS_OFF_MAIN |=>
    rd_valid_o && rd_data_o == {13'h0000, $past(s_q.main_st)})
    else $error("main state word wrong");
  // Comm state readback two cycles after change
  link_read_a: assert property (
    ##1 rd_en_i && !rd_list_i && rd_addr_i == `MDCS_OFF_LINK |=>
    rd_data_o == {13'h0000, $past(link_st_i, 2)})
    else $error("comm state word wrong");
  // Bitmap bit 0 stays clear
  map_bit0_a: assert property (
    !s_q.err_map[0] && !s_q.poll_map[0] && !s_q.long_map[0])
    else $error("bitmap bit 0 set");
  // Poll bitmap follows input
  poll_map_a: assert property (
    1'b1 |=> s_q.poll_map[15:1] == $past(poll_map_i[15:1]))
    else $error("poll bitmap stale");
  // Long address bitmap follows input
  long_map_a: assert property (
    1'b1 |=> s_q.long_map[15:1] == $past(long_map_i[15:1]))
    else $error("long address bitmap stale");
  // Index copy follows the executing entry
  cmd_idx_a: assert property (
    1'b1 |=> s_q.cmd_idx == $past(cmd_idx_i))
    else $error("command index stale");
  // Request count steps by one and wraps
  req_count_a: assert property (
    req_sent_i |=> s_q.req_cnt == 16'($past(s_q.req_cnt) + 16'h0001))
    else $error("request count wrong");
  // Response count holds without events
  rsp_count_a: assert property (
    !rsp_rcvd_i |=> $stable(s_q.rsp_cnt))
    else $error("response count moved");
  // Last code takes the former current
  last_code_a: assert property (
    err_rpt_i |=> s_q.cur_code == $past(err_code_i) &&
    s_q.last_code == $past(s_q.cur_code))
    else $error("error code history wrong");
  // Enable setting of Y is not flagged
  yes_no_a: assert property (
    cfg_load_i && cfg_i.en_yn == `MDCS_YES |=> !s_q.cfg_err[0])
    else $error("enable flag wrong");
  // Preamble range
  preamble_a: assert property (
    cfg_load_i && cfg_i.preambles == 8'h00 |=> s_q.cfg_err[3])
    else $error("preamble flag missing");
  // Poll time range
  poll_time_a: assert property (
    cfg_load_i |=> s_q.cfg_err[7] == ($past(cfg_i.poll_ms) > 16'h2710))
    else $error("poll time flag wrong");
  // Plain flags pass through, top bit clear
  cfg_flags_a: assert property (
    cfg_load_i |=> s_q.cfg_err[14:8] == $past({cfg_i.init_fail,
    cfg_i.board_absent, cfg_i.mem_buf_fail, cfg_i.mem_fix_fail,
    cfg_i.mem_cmd_fail, cfg_i.cnt_bad, cfg_i.db_bad}) && !s_q.cfg_err[15])
    else $error("config flags wrong");
  // Comm failure encoding
  comm_fail_a: assert property (
    done_i && done_info_i.kind == MDCS_K_COMM && done_info_i.idx < 7'h64
    |=> ret_valid_o && ret_word_o[15] && ret_word_o[7:0] == 8'h00)
    else $error("comm failure word wrong");
  // Reply encoding
  reply_a: assert property (
    done_i && done_info_i.kind == MDCS_K_REPLY && done_info_i.idx < 7'h64
    |=> !ret_word_o[15] && ret_word_o[7:0] == $past(done_info_i.malf))
    else $error("reply word wrong");
  // Timeout stored as all ones in list
  timeout_a: assert property (
    done_i && done_info_i.kind == MDCS_K_TIMEOUT && done_info_i.idx < 7'h64
    |=> s_q.list[$past(done_info_i.idx)] == 16'hffff)
    else $error("timeout word wrong");
  // Database copy at offset
  db_copy_a: assert property (
    ret_valid_o |-> db_wr_o && db_data_o == ret_word_o &&
    db_addr_o == 16'($past(err_off_i) + {9'h000, $past(done_info_i.idx)}))
    else $error("database copy wrong");
  // Main sequencer copy follows its input
  main_copy_a: assert property (
    1'b1 |=> s_q.main_st == $past(main_st_i))
    else $error("main state copy stale");
  // Error bitmap follows input
  err_map_a: assert property (
    1'b1 |=> s_q.err_map[15:1] == $past(err_map_i[15:1]))
    else $error("error bitmap stale");
  // Bitmap words read back with bit 0 clear
  err_map_read_a: assert property (
    rd_en_i && !rd_list_i && rd_addr_i == `MDCS_OFF_ERRMAP |=>
    rd_data_o == ($past(err_map_i, 2) & 16'hfffe))
    else $error("error bitmap word wrong");
  poll_map_read_a: assert property (
    rd_en_i && !rd_list_i && rd_addr_i == `MDCS_OFF_POLLMAP |=>
    rd_data_o == ($past(poll_map_i, 2) & 16'hfffe))
    else $error("poll bitmap word wrong");
  // Index word reads the entry two edges back
  cmd_idx_read_a: assert property (
    rd_en_i && !rd_list_i && rd_addr_i == `MDCS_OFF_CMDIDX |=>
    rd_data_o == {9'h000, $past(cmd_idx_i, 2)})
    else $error("command index word wrong");
  // Response count steps by one and wraps
  rsp_step_a: assert property (
    rsp_rcvd_i |=> s_q.rsp_cnt == 16'($past(s_q.rsp_cnt) + 16'h0001))
    else $error("response count step wrong");
  // Request count holds without events
  req_hold_a: assert property (
    !req_sent_i |=> $stable(s_q.req_cnt))
    else $error("request count moved");
  // Counter word reads the registered count
  req_read_a: assert property (
    rd_en_i && !rd_list_i && rd_addr_i == `MDCS_OFF_REQCNT |=>
    rd_data_o == $past(s_q.req_cnt))
    else $error("request count word wrong");
  // Every yes/no setting outside Y or N is flagged
  yn_bits_a: assert property (
    cfg_load_i |=>
    s_q.cfg_err[0] == !($past(cfg_i.en_yn) inside {8'h59, 8'h4e}) &&
    s_q.cfg_err[1] == !($past(cfg_i.hh_yn) inside {8'h59, 8'h4e}) &&
    s_q.cfg_err[2] == !($past(cfg_i.pm_yn) inside {8'h59, 8'h4e}))
    else $error("yes/no flags wrong");
  // Preamble and retry counts outside their ranges
  count_range_a: assert property (
    cfg_load_i |=> s_q.cfg_err[3] == ($past(cfg_i.preambles) == 8'h00 ||
    $past(cfg_i.preambles) > 8'h32) &&
    s_q.cfg_err[4] == ($past(cfg_i.short_rty) > 8'h32) &&
    s_q.cfg_err[5] == ($past(cfg_i.long_rty) > 8'h32) &&
    s_q.cfg_err[6] == ($past(cfg_i.err_rty) > 8'h32))
    else $error("count range flags wrong");
  // Configuration word holds between loads and reads back
  cfg_hold_a: assert property (
    !cfg_load_i |=> $stable(s_q.cfg_err))
    else $error("config word moved");
  cfg_read_a: assert property (
    rd_en_i && !rd_list_i && rd_addr_i == `MDCS_OFF_CFGERR |=>
    rd_data_o == $past(s_q.cfg_err))
    else $error("config word read wrong");
  // Error codes hold between reports, current code reads back
  code_hold_a: assert property (
    !err_rpt_i |=> $stable(s_q.cur_code) && $stable(s_q.last_code))
    else $error("error codes moved");
  cur_read_a: assert property (
    rd_en_i && !rd_list_i && rd_addr_i == `MDCS_OFF_CURCODE |=>
    rd_data_o == $past(s_q.cur_code))
    else $error("current code word wrong");
  // Error code lands in the upper byte
  comm_code_a: assert property (
    done_i && done_info_i.kind == MDCS_K_COMM && done_info_i.idx < 7'h64
    |=> ret_word_o[14:8] == $past(done_info_i.code))
    else $error("comm failure code wrong");
  reply_code_a: assert property (
    done_i && done_info_i.kind == MDCS_K_REPLY && done_info_i.idx < 7'h64
    |=> ret_word_o[14:8] == $past(done_info_i.code))
    else $error("command error code wrong");
  // Entries beyond the list give no output
  out_range_a: assert property (
    done_i && done_info_i.idx >= 7'h64 |=> !ret_valid_o && !db_wr_o)
    else $error("entry beyond list reported");
  // Database writes only come with a returned word
  db_wr_only_a: assert property (
    db_wr_o |-> ret_valid_o)
    else $error("stray database write");
  // List words read back by index
  list_read_a: assert property (
    rd_en_i && rd_list_i && rd_addr_i < 7'h64 |=>
    rd_data_o == $past(s_q.list[rd_addr_i]))
    else $error("list word read wrong");
  // Every read is answered on the next edge, and only then
  read_pulse_a: assert property (
    rd_valid_o == $past(rd_en_i))
    else $error("read valid timing wrong");

  timeout_c: cover property (done_i && done_info_i.kind == MDCS_K_TIMEOUT);
  comm_c: cover property (done_i && done_info_i.kind == MDCS_K_COMM);
  reply_c: cover property (done_i && done_info_i.kind == MDCS_K_REPLY);
  wrap_c: cover property (req_sent_i && s_q.req_cnt == 16'hffff);
  cfg_read_c: cover property (cfg_load_i ##1 rd_en_i && !rd_list_i &&
    rd_addr_i == `MDCS_OFF_CFGERR);
endmodule : mdcs_status

// >>> bench/mdcs_field_model.sv
// Field device side of one channel: request, response and done pulses.
// Assumes the bench calls its tasks at the falling clock edge.
`timescale 1ns/1ps
module mdcs_field_model (
  input wire logic mclk_i, // Bank clock
  output logic req_sent_o, // Request sent pulse
  output logic rsp_rcvd_o, // Response seen pulse
  output logic done_o, // Command ended pulse
  output mdcs_pkg::mdcs_done_t info_o // Command outcome
);
  import mdcs_pkg::*;
  // Quiet lines at time zero
  initial begin
    req_sent_o = 1'b0;
    rsp_rcvd_o = 1'b0;
    done_o = 1'b0;
    info_o = '0;
  end
  // Hold the request line high for n cycles, one count each
  task automatic burst(input int n);
    req_sent_o = 1'b1;
    repeat (n) @(negedge mclk_i);
    req_sent_o = 1'b0;
  endtask : burst
  // One command: request, a reply after lag cycles unless silent, end
  task automatic run(input mdcs_done_t d, input int lag);
    burst(1);
    repeat (lag) @(negedge mclk_i);
    rsp_rcvd_o = (d.kind == MDCS_K_REPLY);
    @(negedge mclk_i);
    rsp_rcvd_o = 1'b0;
    done_o = 1'b1;
    info_o = d;
    @(negedge mclk_i);
    done_o = 1'b0;
    // Outcome no longer valid: show its inverse, not the old value
    info_o = ~d;
  endtask : run
endmodule : mdcs_field_model

// >>> bench/mdcs_status_tb.sv
// Self-checking bench of the channel status bank.
// Assumes the bank answers reads and command ends one cycle later.
`timescale 1ns/1ps
`include "mdcs_regs.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module mdcs_status_tb;
  import mdcs_pkg::*;
  logic mclk_i = 1'b0, rst_b_i = 1'b0; // Clock and reset
  mdcs_main_t main_st_i = MDCS_M_POLL; // Main sequencer
  mdcs_link_t link_st_i = MDCS_L_START; // Comm sequencer
  logic [15:0] err_map_i = '0, poll_map_i = '0, long_map_i = '0; // Maps
  logic [6:0] cmd_idx_i = '0, rd_addr_i = '0; // Index, read address
  logic cfg_load_i = 1'b0, err_rpt_i = 1'b0; // Event pulses
  logic rd_en_i = 1'b0, rd_list_i = 1'b0; // Read strobe, select
  mdcs_cfg_t cfg_i = '0; // Settings
  logic [15:0] err_code_i = '0, err_off_i = '0; // Code, list base
  logic req_sent, rsp_rcvd, done; // From field model
  mdcs_done_t done_info; // From field model
  logic [15:0] rd_data_o, ret_word_o, db_addr_o, db_data_o; // Outputs
  logic rd_valid_o, ret_valid_o, db_wr_o; // Output strobes
  int err_count = 0, checked = 0, i; // Tallies, loop
  logic [15:0] rq[$], req_n = '0, rsp_n = '0, cur = '0, exp_rd; // Model
  logic [31:0] wq[$], exp_rt; // Pending command words
  logic [15:0] lw[0:100]; // Expected list words
  logic [6:0] a; // Address loop
  // Clock at 100 MHz
  always #5 mclk_i = ~mclk_i;
  mdcs_field_model i_fd (.mclk_i(mclk_i), .req_sent_o(req_sent),
    .rsp_rcvd_o(rsp_rcvd), .done_o(done), .info_o(done_info));
  mdcs_status i_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .main_st_i(main_st_i), .link_st_i(link_st_i), .err_map_i(err_map_i),
    .poll_map_i(poll_map_i), .long_map_i(long_map_i), .cmd_idx_i(cmd_idx_i),
    .req_sent_i(req_sent), .rsp_rcvd_i(rsp_rcvd), .cfg_load_i(cfg_load_i),
    .cfg_i(cfg_i), .err_rpt_i(err_rpt_i), .err_code_i(err_code_i),
    .done_i(done), .done_info_i(done_info), .err_off_i(err_off_i),
    .rd_en_i(rd_en_i), .rd_list_i(rd_list_i), .rd_addr_i(rd_addr_i),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .ret_word_o(ret_word_o),
    .ret_valid_o(ret_valid_o), .db_wr_o(db_wr_o), .db_addr_o(db_addr_o),
    .db_data_o(db_data_o));
  // Verdict and end of run
  task automatic wrap_up();
    if (err_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  // Monitor: each answer takes the oldest expectation off its queue
  always @(negedge mclk_i) begin
    if (rd_valid_o === 1'b1) begin
      exp_rd = (rq.size() > 0) ? rq.pop_front() : 16'hdead;
      `CHK(rd_data_o, exp_rd)
    end
    if (ret_valid_o === 1'b1) begin
      exp_rt = (wq.size() > 0) ? wq.pop_front() : 32'hdeadbeef;
      `CHK(ret_word_o, exp_rt[15:0])
      `CHK({db_wr_o, db_addr_o, db_data_o}, {1'b1, exp_rt})
    end
  end
  // One read, answered exactly one cycle after it is taken
  task automatic rd(input logic l, input logic [6:0] ad, input logic [15:0] e);
    rd_en_i = 1'b1;
    rd_list_i = l;
    rd_addr_i = ad;
    rq.push_back(e);
    @(negedge mclk_i);
    rd_en_i = 1'b0;
    @(negedge mclk_i);
    `CHK(rq.size() == 0, 1'b1)
  endtask : rd
  // A yes/no setting: valid codes, lower case or random junk
  function automatic logic [7:0] yn();
    int r;
    r = $urandom_range(0, 4);
    return r == 0 ? `MDCS_YES : r == 1 ? `MDCS_NO : r == 2 ? 8'h79 :
      8'($urandom);
  endfunction : yn
  // Expected configuration word worked out from the settings
  function automatic logic [15:0] cfg_exp(mdcs_cfg_t c);
    logic [15:0] e;
    e = '0;
    e[0] = !(c.en_yn inside {`MDCS_YES, `MDCS_NO});
    e[1] = !(c.hh_yn inside {`MDCS_YES, `MDCS_NO});
    e[2] = !(c.pm_yn inside {`MDCS_YES, `MDCS_NO});
    e[3] = c.preambles < 8'h01 || c.preambles > 8'h32;
    e[4] = c.short_rty > 8'h32;
    e[5] = c.long_rty > 8'h32;
    e[6] = c.err_rty > 8'h32;
    e[7] = c.poll_ms > 16'h2710;
    e[14:8] = {c.init_fail, c.board_absent, c.mem_buf_fail, c.mem_fix_fail,
      c.mem_cmd_fail, c.cnt_bad, c.db_bad};
    return e;
  endfunction : cfg_exp
  // One command through the field model, with its expected word
  task automatic cmd(input mdcs_kind_t k, input logic [6:0] ix, input int lag);
    mdcs_done_t d;
    logic [15:0] w;
    d.idx = ix;
    d.kind = k;
    d.code = 7'($urandom);
    d.malf = 8'($urandom);
    w = k == MDCS_K_TIMEOUT ? 16'hffff : k == MDCS_K_COMM ?
      {1'b1, d.code, 8'h00} : {1'b0, d.code, d.malf};
    req_n++;
    if (k == MDCS_K_REPLY) rsp_n++;
    if (ix < 7'h64) begin
      wq.push_back({err_off_i + 16'(ix), w});
      lw[ix] = w;
    end
    i_fd.run(d, lag);
  endtask : cmd
  // Main sequence
  initial begin
    void'($urandom(32'h9175be70));
    for (i = 0; i <= 100; i++) lw[i] = '0;
    repeat (5) @(negedge mclk_i);
    rst_b_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    // Status words read zero after reset, some spare and unmapped ones too
    for (a = 7'h30; a <= 7'h3d; a++) rd(1'b0, a, 16'h0000);
    rd(1'b0, 7'h10, 16'h0000);
    // Sequencer values, maps and index follow their inputs
    for (i = 0; i < 8; i++) begin
      main_st_i = mdcs_main_t'($urandom_range(0, 4));
      link_st_i = mdcs_link_t'($urandom_range(0, 6));
      err_map_i = 16'($urandom);
      poll_map_i = 16'($urandom);
      long_map_i = 16'($urandom);
      cmd_idx_i = 7'($urandom_range(0, 99));
      @(negedge mclk_i);
      rd(1'b0, `MDCS_OFF_MAIN, 16'(main_st_i));
      rd(1'b0, `MDCS_OFF_LINK, 16'(link_st_i));
      rd(1'b0, `MDCS_OFF_ERRMAP, err_map_i & 16'hfffe);
      rd(1'b0, `MDCS_OFF_POLLMAP, poll_map_i & 16'hfffe);
      rd(1'b0, `MDCS_OFF_LONGMAP, long_map_i & 16'hfffe);
      rd(1'b0, `MDCS_OFF_CMDIDX, 16'(cmd_idx_i));
    end
    // Settings near every limit, judged on each load
    for (i = 0; i < 24; i++) begin
      cfg_i = {yn(), yn(), yn(),
        8'(i < 2 ? i * 51 : $urandom_range(0, 51)),
        8'($urandom_range(49, 51)), 8'($urandom_range(49, 51)),
        8'($urandom_range(49, 51)), 16'($urandom_range(9999, 10001)),
        7'($urandom) & 7'($urandom)};
      cfg_load_i = 1'b1;
      @(negedge mclk_i);
      cfg_load_i = 1'b0;
      rd(1'b0, `MDCS_OFF_CFGERR, cfg_exp(cfg_i));
    end
    // Error reports: the old present code moves to the previous word
    for (i = 0; i < 3; i++) begin
      err_code_i = 16'($urandom);
      err_rpt_i = 1'b1;
      @(negedge mclk_i);
      err_rpt_i = 1'b0;
      rd(1'b0, `MDCS_OFF_LASTCODE, cur);
      cur = err_code_i;
      rd(1'b0, `MDCS_OFF_CURCODE, cur);
    end
    // Commands of every kind; base near the top so addresses wrap
    err_off_i = 16'hfff0;
    for (i = 0; i < 16; i++)
      cmd(mdcs_kind_t'(i % 3), i % 4 == 0 ? 7'd0 : i % 4 == 1 ? 7'd99 :
        i % 4 == 2 ? 7'd100 : 7'($urandom_range(0, 99)), i % 5);
    for (i = 0; i <= 100; i++) rd(1'b1, 7'(i), lw[i]);
    rd(1'b0, `MDCS_OFF_REQCNT, req_n);
    rd(1'b0, `MDCS_OFF_RSPCNT, rsp_n);
    // Request counter wraps past its top
    i_fd.burst(65535);
    req_n = req_n + 16'hffff;
    @(negedge mclk_i);
    rd(1'b0, `MDCS_OFF_REQCNT, req_n);
    wrap_up();
  end
  // Watchdog well past the expected run length
  initial begin
    #1000000;
    err_count++;
    wrap_up();
  end
endmodule : mdcs_status_tb
